// ---- spf_pkg.sv ----
// Shared constants and carrier types for the switch port policy filter
`default_nettype none
package spf_pkg;
  localparam int PORT_NUM = 3;
  localparam logic [1:0] PORT_ONE = 2'h0;
  localparam logic [1:0] PORT_TWO = 2'h1;
  localparam logic [1:0] PORT_HOST = 2'h2;
  localparam logic [2:0] HOST_MASK = 3'h4;
  // Register byte offsets
  localparam logic [7:0] OFF_PORT_ONE_CTRL2 = 8'h00;
  localparam logic [7:0] OFF_PORT_TWO_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_HOST_CTRL2 = 8'h08;
  localparam logic [7:0] OFF_GLOBAL_CTRL2 = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [2:0] IDX_GLOBAL = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h7;
  // Per-port control field positions
  localparam int PC_RX_SNIFF = 0;
  localparam int PC_TX_SNIFF = 1;
  localparam int PC_SNIFFER = 2;
  localparam int PC_LEARN_DIS = 4;
  localparam int PC_RX_EN = 5;
  localparam int PC_TX_EN = 6;
  localparam logic [6:0] PORT_CTRL_RESET = 7'h60;
  localparam logic [6:0] PORT_CTRL_WMASK = 7'h77;
  // Global control two field positions
  localparam int GC_MLD_EN = 13;
  localparam int GC_MLD_OPT = 12;
  localparam int GC_SNIFF_AND = 8;
  localparam int GC_BAD_MIRROR = 0;
  localparam logic [13:0] GLOBAL_RESET = 14'h0000;
  localparam logic [13:0] GLOBAL_WMASK = 14'h3101;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // Packet classification values
  localparam logic [3:0] IPV4_VERSION = 4'h4;
  localparam logic [7:0] IGMP_PROTO = 8'h02;
  localparam logic [7:0] MLD_HOP_LIMIT = 8'h01;
  localparam logic [7:0] NH_HOP_BY_HOP = 8'h00;
  localparam logic [7:0] NH_ICMP = 8'h01;
  localparam logic [7:0] NH_ICMPV6 = 8'h3A;
  localparam logic [7:0] NH_ROUTING = 8'h2B;
  localparam logic [7:0] NH_FRAGMENT = 8'h2C;
  localparam logic [7:0] NH_ESP = 8'h32;
  localparam logic [7:0] NH_AUTH = 8'h33;
  localparam logic [7:0] NH_DEST_OPT = 8'h3C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] srcPort;
    logic [2:0] lookupPorts;
    logic staticHit;
    logic staticOverride;
    logic [2:0] staticPorts;
    logic badFrame;
    logic ethIp;
    logic snapIp;
    logic [3:0] ipVersion;
    logic [7:0] ipProtocol;
    logic ipv6;
    logic dstMulticast;
    logic [7:0] hopLimit;
    logic [7:0] nextHeader;
    logic [7:0] hbhNextHeader;
  } spf_frame_type;

  typedef struct packed {
    logic [2:0] destPorts;
    logic learnEnable;
    logic trapped;
    logic mirrored;
  } spf_verdict_type;
endpackage : spf_pkg
`default_nettype wire

// ---- spf_policy_filter.sv ----
// Forwarding policy stage: port states, trapping, mirroring, AXI4-Lite regs
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`default_nettype none
module spf_policy_filter #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frameValid,
  input wire spf_pkg::spf_frame_type frameIn,
  output logic verdictValid,
  output spf_pkg::spf_verdict_type verdictOut
);
  if (ADDR_W < 5 || ADDR_W > 32) begin : gBadAddrW
    $error("ADDR_W must lie between 5 and 32");
  end

  function automatic logic [2:0] regIndex(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    if (addr != ADDR_W'(a)) return spf_pkg::IDX_NONE;
    case (a)
      spf_pkg::OFF_PORT_ONE_CTRL2: return 3'h0;
      spf_pkg::OFF_PORT_TWO_CTRL2: return 3'h1;
      spf_pkg::OFF_HOST_CTRL2: return 3'h2;
      spf_pkg::OFF_GLOBAL_CTRL2: return spf_pkg::IDX_GLOBAL;
      spf_pkg::OFF_STATUS: return spf_pkg::IDX_STATUS;
      default: return spf_pkg::IDX_NONE;
    endcase
  endfunction : regIndex

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : mergeStrb

  function automatic logic [2:0] portMask(input logic [1:0] idx);
    case (idx)
      spf_pkg::PORT_ONE: return 3'h1;
      spf_pkg::PORT_TWO: return 3'h2;
      spf_pkg::PORT_HOST: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction : portMask

  // Trap header match, used for the direct and the hop-by-hop header
  function automatic logic mldHeader(input logic [7:0] nh, input logic opt);
    logic ext;
    ext = nh == spf_pkg::NH_ROUTING || nh == spf_pkg::NH_FRAGMENT ||
          nh == spf_pkg::NH_ESP || nh == spf_pkg::NH_AUTH ||
          nh == spf_pkg::NH_DEST_OPT;
    return nh == spf_pkg::NH_ICMP || nh == spf_pkg::NH_ICMPV6 ||
           (opt && ext);
  endfunction : mldHeader

  // Register file and bus state
  logic [2:0][6:0] portCtrl_q, portCtrl_d;
  logic [13:0] globalCtrl_q, globalCtrl_d;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] trapCount_q, trapCount_d, mirrorCount_q, mirrorCount_d;
  logic [2:0] wIdx, rIdx;
  logic [31:0] wMerged;

  always_comb begin : busNext
    portCtrl_d = portCtrl_q;
    globalCtrl_d = globalCtrl_q;
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d = wHeld_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    wIdx = regIndex(awAddr_q);
    rIdx = regIndex(s_axi_araddr);
    wMerged = 32'h00000000;
    if (s_axi_bready && bvalid_q) bvalid_d = 1'b0;
    // Address and data may arrive in either order
    if (s_axi_awvalid && awready_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (awHeld_q && wHeld_q && !bvalid_q) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = spf_pkg::RESP_OKAY;
      if (wIdx < spf_pkg::IDX_GLOBAL) begin
        wMerged = mergeStrb({25'h0000000, portCtrl_q[wIdx[1:0]]},
                            wData_q, wStrb_q);
        portCtrl_d[wIdx[1:0]] = wMerged[6:0] & spf_pkg::PORT_CTRL_WMASK;
      end else if (wIdx == spf_pkg::IDX_GLOBAL) begin
        wMerged = mergeStrb({18'h00000, globalCtrl_q}, wData_q, wStrb_q);
        globalCtrl_d = wMerged[13:0] & spf_pkg::GLOBAL_WMASK;
      end else if (wIdx != spf_pkg::IDX_STATUS) begin
        bresp_d = spf_pkg::RESP_SLVERR;
      end
    end
    awready_d = !awHeld_d;
    wready_d = !wHeld_d;
    if (s_axi_rready && rvalid_q) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = spf_pkg::RESP_OKAY;
      case (rIdx)
        3'h0, 3'h1, 3'h2: rdata_d = {25'h0000000, portCtrl_q[rIdx[1:0]]};
        spf_pkg::IDX_GLOBAL: rdata_d = {18'h00000, globalCtrl_q};
        spf_pkg::IDX_STATUS: rdata_d = {mirrorCount_q, trapCount_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = spf_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin : busRegs
    if (rst) begin
      portCtrl_q <= {3{spf_pkg::PORT_CTRL_RESET}};
      globalCtrl_q <= spf_pkg::GLOBAL_RESET;
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= spf_pkg::RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= spf_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      portCtrl_q <= portCtrl_d;
      globalCtrl_q <= globalCtrl_d;
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q <= wHeld_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Per-port control vectors, index 2 is the host port
  logic [2:0] rxSniffVec, txSniffVec, snifferVec, learnDisVec, rxEnVec;
  logic [2:0] txEnVec;
  for (genvar p = 0; p < spf_pkg::PORT_NUM; p++) begin : gPortVec
    assign rxSniffVec[p] = portCtrl_q[p][spf_pkg::PC_RX_SNIFF];
    assign txSniffVec[p] = portCtrl_q[p][spf_pkg::PC_TX_SNIFF];
    assign snifferVec[p] = portCtrl_q[p][spf_pkg::PC_SNIFFER];
    // Host port is never gated by its spanning-tree bits
    if (p == spf_pkg::PORT_NUM - 1) begin : gHost
      assign learnDisVec[p] = 1'b0;
      assign rxEnVec[p] = 1'b1;
      assign txEnVec[p] = 1'b1;
    end else begin : gNet
      assign learnDisVec[p] = portCtrl_q[p][spf_pkg::PC_LEARN_DIS];
      assign rxEnVec[p] = portCtrl_q[p][spf_pkg::PC_RX_EN];
      assign txEnVec[p] = portCtrl_q[p][spf_pkg::PC_TX_EN];
    end
  end

  // Verdict pipeline, one cycle from frame to verdict
  logic verdictValid_q, verdictValid_d;
  spf_pkg::spf_verdict_type verdict_q, verdict_d;
  logic [2:0] srcMask, base, fwd, sniffMask;
  logic netSrc, rxEnSrc, overrideHit, igmpHit, mldHit, trap;
  logic rxMir, txMir, mirror;

  always_comb begin : policyNext
    srcMask = portMask(frameIn.srcPort);
    netSrc = srcMask != spf_pkg::HOST_MASK;
    rxEnSrc = |(srcMask & rxEnVec);
    overrideHit = frameIn.staticHit && frameIn.staticOverride;
    // Static entry wins over the learned or flooded lookup
    base = (frameIn.staticHit ? frameIn.staticPorts
                              : frameIn.lookupPorts) & ~srcMask;
    igmpHit = (frameIn.ethIp || frameIn.snapIp) &&
              frameIn.ipVersion == spf_pkg::IPV4_VERSION &&
              frameIn.ipProtocol == spf_pkg::IGMP_PROTO;
    mldHit = globalCtrl_q[spf_pkg::GC_MLD_EN] && frameIn.ipv6 &&
             frameIn.dstMulticast &&
             frameIn.hopLimit == spf_pkg::MLD_HOP_LIMIT &&
             (mldHeader(frameIn.nextHeader,
                        globalCtrl_q[spf_pkg::GC_MLD_OPT]) ||
              (frameIn.nextHeader == spf_pkg::NH_HOP_BY_HOP &&
               mldHeader(frameIn.hbhNextHeader,
                         globalCtrl_q[spf_pkg::GC_MLD_OPT])));
    trap = netSrc && (igmpHit || mldHit);
    // Host-sent frames pass any port state; software keeps them away
    fwd = netSrc ? (base & txEnVec) : base;
    if (!rxEnSrc) begin
      fwd = overrideHit ? (base & spf_pkg::HOST_MASK) : 3'h0;
    end
    // Rx-disabled port keeps only its override delivery
    if (trap && rxEnSrc) fwd = spf_pkg::HOST_MASK;
    if (frameIn.badFrame) fwd = 3'h0;
    rxMir = rxEnSrc && |(srcMask & rxSniffVec);
    txMir = |(fwd & txSniffVec);
    mirror = globalCtrl_q[spf_pkg::GC_SNIFF_AND] ? (rxMir && txMir)
                                                 : (rxMir || txMir);
    if (frameIn.badFrame) begin
      mirror = rxMir && globalCtrl_q[spf_pkg::GC_BAD_MIRROR] &&
               !globalCtrl_q[spf_pkg::GC_SNIFF_AND];
    end
    // OR keeps a single copy where the sniffer is already a target
    sniffMask = snifferVec & ~srcMask;
    verdict_d.destPorts = mirror ? (fwd | sniffMask) : fwd;
    if (trap) verdict_d.destPorts = verdict_d.destPorts & spf_pkg::HOST_MASK;
    verdict_d.learnEnable = |srcMask && !frameIn.badFrame &&
                            !(|(srcMask & learnDisVec));
    if (srcMask == 3'h0) verdict_d.destPorts = 3'h0;
    verdict_d.trapped = trap && rxEnSrc;
    verdict_d.mirrored = mirror && |(sniffMask & ~fwd);
    verdictValid_d = frameValid;
    if (!frameValid) verdict_d = verdict_q;
    trapCount_d = trapCount_q;
    mirrorCount_d = mirrorCount_q;
    if (frameValid && verdict_d.trapped) trapCount_d = trapCount_q + 16'h0001;
    if (frameValid && verdict_d.mirrored) begin
      mirrorCount_d = mirrorCount_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin : policyRegs
    if (rst) begin
      verdictValid_q <= 1'b0;
      verdict_q <= '0;
      trapCount_q <= spf_pkg::COUNT_RESET;
      mirrorCount_q <= spf_pkg::COUNT_RESET;
    end else begin
      verdictValid_q <= verdictValid_d;
      verdict_q <= verdict_d;
      trapCount_q <= trapCount_d;
      mirrorCount_q <= mirrorCount_d;
    end
  end

  assign verdictValid = verdictValid_q;
  assign verdictOut = verdict_q;

  default clocking cbDef @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_host_never_gated: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_HOST &&
    !frameIn.badFrame && frameIn.lookupPorts[0] && !frameIn.staticHit
    |=> verdictOut.destPorts[0])
    else $error("host frame blocked by port state");
  a_disabled_drop: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_ONE &&
    !portCtrl_q[0][spf_pkg::PC_RX_EN] && !frameIn.staticOverride &&
    snifferVec == 3'h0
    |=> verdictValid && verdictOut.destPorts == 3'h0)
    else $error("disabled port forwarded a frame");
  a_override_host: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_TWO &&
    !portCtrl_q[1][spf_pkg::PC_RX_EN] && frameIn.staticHit &&
    frameIn.staticOverride && frameIn.staticPorts[2] && !frameIn.badFrame
    |=> verdictOut.destPorts[2] &&
        verdictOut.learnEnable != $past(portCtrl_q[1][spf_pkg::PC_LEARN_DIS]))
    else $error("override frame not delivered to host");
  a_tx_gate: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_ONE &&
    !portCtrl_q[1][spf_pkg::PC_TX_EN] && !snifferVec[1]
    |=> !verdictOut.destPorts[1])
    else $error("frame sent out of transmit-disabled port");
  a_learn_gate: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_TWO &&
    portCtrl_q[1][spf_pkg::PC_LEARN_DIS]
    |=> verdictValid && !verdictOut.learnEnable)
    else $error("learning on learn-disabled port");
  a_forward_state: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_ONE &&
    portCtrl_q[0][6:4] == 3'h6 && portCtrl_q[1][spf_pkg::PC_TX_EN] &&
    !frameIn.badFrame && !frameIn.staticHit && frameIn.lookupPorts[1] &&
    !frameIn.ethIp && !frameIn.snapIp && !frameIn.ipv6
    |=> verdictOut.destPorts[1] && verdictOut.learnEnable)
    else $error("forwarding state did not forward");
  a_igmp_trap: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_ONE &&
    portCtrl_q[0][spf_pkg::PC_RX_EN] && frameIn.snapIp &&
    frameIn.ipVersion == spf_pkg::IPV4_VERSION &&
    frameIn.ipProtocol == spf_pkg::IGMP_PROTO
    |=> verdictOut.trapped && verdictOut.destPorts == spf_pkg::HOST_MASK)
    else $error("IGMP frame not trapped to host");
  a_mld_off: assert property (
    frameValid && !globalCtrl_q[spf_pkg::GC_MLD_EN] && !frameIn.ethIp &&
    !frameIn.snapIp
    |=> !verdictOut.trapped)
    else $error("trap while MLD snooping off");
  a_mld_option: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_TWO &&
    portCtrl_q[1][spf_pkg::PC_RX_EN] && globalCtrl_q[13:12] == 2'h3 &&
    frameIn.ipv6 && frameIn.dstMulticast &&
    frameIn.hopLimit == spf_pkg::MLD_HOP_LIMIT &&
    frameIn.nextHeader == spf_pkg::NH_HOP_BY_HOP &&
    frameIn.hbhNextHeader == spf_pkg::NH_DEST_OPT
    |=> verdictOut.trapped && trapCount_q == $past(trapCount_q) + 16'h0001)
    else $error("MLD option header not trapped or counted");
  a_static_mcast: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_HOST &&
    frameIn.staticHit && !frameIn.badFrame && snifferVec == 3'h0
    |=> verdictOut.destPorts == ($past(frameIn.staticPorts) & 3'h3))
    else $error("static entry ports not honoured");
  a_rx_mirror: assert property (
    frameValid && frameIn.srcPort == spf_pkg::PORT_ONE &&
    portCtrl_q[0][spf_pkg::PC_RX_EN] && rxSniffVec[0] && snifferVec[2] &&
    !globalCtrl_q[spf_pkg::GC_SNIFF_AND] && !frameIn.badFrame
    |=> verdictOut.destPorts[2])
    else $error("receive sniff copy missing");
  a_bad_mirror: assert property (
    frameValid && frameIn.badFrame && !globalCtrl_q[spf_pkg::GC_BAD_MIRROR]
    |=> verdictOut.destPorts == 3'h0)
    else $error("bad frame forwarded without mirror option");
  a_and_mode: assert property (
    frameValid && globalCtrl_q[spf_pkg::GC_SNIFF_AND] &&
    txSniffVec == 3'h0 && !frameIn.badFrame
    |=> !verdictOut.mirrored)
    else $error("AND mode mirrored without transmit sniff");

  c_trap_seen: cover property (verdictValid && verdictOut.trapped);
  c_mirror_seen: cover property (verdictValid && verdictOut.mirrored);
  c_write_then_read: cover property (s_axi_bvalid ##[1:8] s_axi_rvalid);
endmodule : spf_policy_filter
`default_nettype wire

// ---- spf_axi_host.sv ----
// Host processor model: AXI4-Lite register master
`default_nettype none
module spf_axi_host (
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // Released address and data lines show the inverse, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1 && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready === 1'b1 && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : spf_axi_host
`default_nettype wire

// ---- spf_policy_filter_tb_top.sv ----
// Self-checking bench for the port policy filter
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errTotal++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module spf_policy_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, frameValid, verdictValid, t;
  spf_pkg::spf_frame_type frameIn, fb;
  spf_pkg::spf_verdict_type verdictOut, ev;
  spf_pkg::spf_verdict_type expQ[$];
  int errTotal = 0;
  int checks = 0;
  int cyc = 0;
  int nTrap = 0;
  int nMir = 0;
  logic [31:0] lfsr = 32'h222A;
  logic [7:0] nhs [7] = '{8'h01, 8'h3A, 8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C};
  always #12.5 clk_sys = ~clk_sys;
  spf_policy_filter i_spf_policy_filter (.clk_sys, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .frameValid, .frameIn, .verdictValid, .verdictOut);
  spf_axi_host i_spf_axi_host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic spf_pkg::spf_frame_type mk(input logic [1:0] s,
                                               input logic [2:0] lk);
    spf_pkg::spf_frame_type f;
    f = '0;
    f.srcPort = s;
    f.lookupPorts = lk;
    return f;
  endfunction : mk
  // Expected flags: learn 4, trapped 2, mirrored 1
  task automatic snd(input spf_pkg::spf_frame_type f, input logic [2:0] d,
                     input logic [2:0] e);
    @(posedge clk_sys);
    frameValid <= 1'b1;
    frameIn <= f;
    expQ.push_back({d, e});
    nTrap += e[1];
    nMir += e[0];
  endtask : snd
  task automatic idl;
    @(posedge clk_sys);
    frameValid <= 1'b0;
    frameIn <= ~frameIn;
  endtask : idl
  task automatic rw(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    idl();
    i_spf_axi_host.wr(a, d, rsp);
    `CHK(rsp, e)
  endtask : rw
  task automatic rr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    i_spf_axi_host.rd(a, rdv, rsp);
    `CHK(rdv, d)
    `CHK(rsp, e)
  endtask : rr
  task automatic complete_run;
    $display("checks %0d errTotal %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Run is well under 3000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errTotal++;
      complete_run();
    end else if (verdictValid === 1'b1) begin
      ev = expQ.pop_front();
      `CHK(verdictOut, ev)
    end
  end
  initial begin
    frameValid = 1'b0;
    frameIn = '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rr(8'h00, 32'h60, 2'h0);
    rr(8'h0C, 32'h0, 2'h0);
    rr(8'h14, 32'h0, 2'h2);
    rw(8'h14, 32'h1, 2'h2);
    rw(8'h10, 32'hFFFFFFFF, 2'h0);
    rr(8'h10, 32'h0, 2'h0);
    repeat (6) begin
      lfsr = nxt(lfsr);
      snd(mk(2'h0, {lfsr[1], 2'h2}), {lfsr[1], 2'h2}, 3'h4);
    end
    fb = mk(2'h0, 3'h2);
    fb.ethIp = 1'b1;
    fb.ipVersion = 4'h4;
    fb.ipProtocol = 8'h02;
    snd(fb, 3'h4, 3'h6);
    fb.ethIp = 1'b0;
    fb.snapIp = 1'b1;
    snd(fb, 3'h4, 3'h6);
    fb.ipProtocol = 8'h06;
    snd(fb, 3'h2, 3'h4);
    for (int g = 1; g < 4; g++) begin
      rw(8'h0C, {18'h0, g[1:0], 12'h0}, 2'h0);
      for (int i = 0; i < 14; i++) begin
        fb = mk(2'h1, 3'h1);
        fb.ipv6 = 1'b1;
        fb.dstMulticast = 1'b1;
        fb.hopLimit = 8'h01;
        fb.nextHeader = i < 7 ? nhs[i] : 8'h00;
        fb.hbhNextHeader = nhs[i % 7];
        t = g[1] && (i % 7 < 2 || g[0]);
        snd(fb, t ? 3'h4 : 3'h1, t ? 3'h6 : 3'h4);
      end
      fb.hopLimit = 8'h02;
      snd(fb, 3'h1, 3'h4);
    end
    fb = mk(2'h1, 3'h5);
    fb.dstMulticast = 1'b1;
    fb.staticHit = 1'b1;
    fb.staticPorts = 3'h4;
    snd(fb, 3'h4, 3'h4);
    fb.staticPorts = 3'h1;
    snd(fb, 3'h1, 3'h4);
    fb.srcPort = 2'h2;
    fb.staticPorts = 3'h3;
    snd(fb, 3'h3, 3'h4);
    // Port one through disable/listening, then learning
    for (int c = 0; c < 2; c++) begin
      rw(8'h00, c ? 32'h0 : 32'h10, 2'h0);
      snd(mk(2'h0, 3'h2), 3'h0, {c[0], 2'h0});
      fb = mk(2'h0, 3'h2);
      fb.staticHit = 1'b1;
      fb.staticOverride = 1'b1;
      fb.staticPorts = 3'h4;
      snd(fb, 3'h4, {c[0], 2'h0});
      snd(mk(2'h2, 3'h1), 3'h1, 3'h4);
      snd(mk(2'h1, 3'h1), 3'h0, 3'h4);
    end
    rw(8'h08, 32'h4, 2'h0);
    rw(8'h00, 32'h61, 2'h0);
    snd(mk(2'h0, 3'h2), 3'h6, 3'h5);
    snd(mk(2'h0, 3'h6), 3'h6, 3'h4);
    // Port two disabled: tx gate, override delivery, no learning
    rw(8'h04, 32'h10, 2'h0);
    snd(mk(2'h0, 3'h2), 3'h4, 3'h5);
    fb.srcPort = 2'h1;
    snd(fb, 3'h4, 3'h0);
    rw(8'h04, 32'h60, 2'h0);
    snd(mk(2'h2, 3'h1), 3'h1, 3'h4);
    fb = mk(2'h0, 3'h2);
    fb.badFrame = 1'b1;
    snd(fb, 3'h0, 3'h0);
    rw(8'h0C, 32'h1, 2'h0);
    snd(fb, 3'h4, 3'h1);
    rw(8'h00, 32'h60, 2'h0);
    rw(8'h04, 32'h62, 2'h0);
    snd(mk(2'h0, 3'h2), 3'h6, 3'h5);
    snd(mk(2'h1, 3'h1), 3'h1, 3'h4);
    rw(8'h00, 32'h61, 2'h0);
    rw(8'h0C, 32'h100, 2'h0);
    snd(mk(2'h0, 3'h2), 3'h6, 3'h5);
    snd(mk(2'h1, 3'h1), 3'h1, 3'h4);
    rw(8'h04, 32'h60, 2'h0);
    snd(mk(2'h0, 3'h2), 3'h2, 3'h4);
    rw(8'h0C, 32'h0, 2'h0);
    rw(8'h04, 32'h64, 2'h0);
    rw(8'h08, 32'h0, 2'h0);
    snd(mk(2'h0, 3'h4), 3'h6, 3'h5);
    idl();
    repeat (4) @(posedge clk_sys);
    rr(8'h10, {nMir[15:0], nTrap[15:0]}, 2'h0);
    `CHK(expQ.size(), 0)
    complete_run();
  end
endmodule : spf_policy_filter_tb_top
`default_nettype wire
